/* mode_cfg_pkg.sv */
// Constants shared by the mode selection and setup latch logic.
// Assumes a 16-bit register address space and an 8-bit register data path.
//
// Summary of operation
// - Mode pins pass a clocked pipeline; levels present before reset release are captured.
// - Captured pin levels load the special-variant and expanded-select bits.
// - After reset release the pins no longer change the mode bits.
// - Outside reset pin A drives low, open-drain, on each instruction's first cycle.
// - Mode register reads anytime; upper four bits are guarded, lower four are priority.
// - Boot ROM enable is writable only in special variant; it maps the ROM.
// - Boot ROM leaves reset disabled and unmapped except in special bootstrap mode.
// - Special test mode leaves reset with boot ROM off, but software may enable it.
// - Special-variant bit may be cleared by software but never set again.
// - Expanded-select bit is writable only while the special-variant bit is one.
// - Echo bit is writable only in special variant, forced zero otherwise.
// - With echo set, internal read data is driven onto the external data bus.
// - Setup register reads return the working register, not the EEPROM byte.
// - Each reset copies the setup EEPROM byte into the working register.
// - EEPROM byte changes reach the working register only at a later reset.
// - The setup byte is a separate location served by the common EEPROM logic.
// - Optionally software writes the working setup register directly in special variant.
// - Special-variant one means bootstrap or test; zero means the normal variation.
// - Special modes leave reset with echo set; once written zero it stays locked.

package mode_cfg_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [ADDR_W-1:0] PRIORITY_MODE_ADDR = 16'h103c;
   localparam logic [ADDR_W-1:0] SETUP_WORK_ADDR = 16'h103f;

   // ****************************************************************
   // Field positions of the priority and mode register
   // ****************************************************************
   localparam int BOOT_ROM_POS = 7;
   localparam int SPECIAL_POS = 6;
   localparam int EXPANDED_POS = 5;
   localparam int ECHO_POS = 4;
   localparam int PRIO_MSB = 3;
   localparam int PRIO_W = 4;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;

   // ****************************************************************
   // Boot ROM window and setup register width
   // ****************************************************************
   localparam logic [ADDR_W-1:0] BOOT_ROM_LO = 16'hbf40;
   localparam logic [ADDR_W-1:0] BOOT_ROM_HI = 16'hbfff;
   localparam int SETUP_BITS_DEF = 4;

endpackage

/* mode_select_config_latch.sv */
// Mode pin capture, mode control register, boot ROM decode, read echo and setup latch.
// Assumes pins arrive asynchronously and all core strobes come from logic on mclk.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module mode_select_config_latch
   import mode_cfg_pkg::*;
#(
   parameter int SETUP_BITS = SETUP_BITS_DEF,
   parameter bit DIRECT_SETUP_WRITE = 1'b0
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic mode_pin_a_in,
   output logic mode_pin_a_out,
   output logic mode_pin_a_oe,
   input wire logic mode_pin_b_in,
   input wire logic instr_start,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic [DATA_W-1:0] setup_eeprom_byte,
   input wire logic [ADDR_W-1:0] cpu_addr,
   output logic boot_rom_hit,
   input wire logic int_read,
   input wire logic [DATA_W-1:0] int_read_data,
   output logic [DATA_W-1:0] ext_data_out,
   output logic ext_data_oe,
   output logic special_variant_bit,
   output logic expanded_select_bit,
   output logic boot_rom_enable,
   output logic internal_read_echo
);

   generate
      if (SETUP_BITS < 1 || SETUP_BITS > DATA_W) begin : g_bad_setup
         $error("SETUP_BITS must lie between 1 and the data width.");
      end
   endgenerate

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Three stages per pin; the filtered level moves only when stages two and three agree.
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic [1:0] pin_s3;
   logic [1:0] pin_stable;
   logic [1:0] next_pin_stable;

   always_comb begin
      next_pin_stable = pin_stable;
      if (pin_s2[0] == pin_s3[0]) begin
         next_pin_stable[0] = pin_s3[0];
      end
      if (pin_s2[1] == pin_s3[1]) begin
         next_pin_stable[1] = pin_s3[1];
      end
   end

   always_ff @(posedge mclk) begin
      pin_s1 <= {mode_pin_b_in, mode_pin_a_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= next_pin_stable;
   end

   // ****************************************************************
   // Decode of register accesses
   // ****************************************************************
   logic wr_mode;
   logic wr_setup;
   logic rd_mode;
   logic rd_setup;

   assign wr_mode = reg_wr && (reg_addr == PRIORITY_MODE_ADDR);
   assign wr_setup = reg_wr && (reg_addr == SETUP_WORK_ADDR);
   assign rd_mode = reg_rd && (reg_addr == PRIORITY_MODE_ADDR);
   assign rd_setup = reg_rd && (reg_addr == SETUP_WORK_ADDR);

   // ****************************************************************
   // Mode control bits
   // ****************************************************************
   logic echo_locked;
   logic [PRIO_W-1:0] prio_sel;
   logic next_special;
   logic next_expanded;
   logic next_boot;
   logic next_echo;
   logic next_echo_locked;
   logic [PRIO_W-1:0] next_prio_sel;

   always_comb begin
      next_special = special_variant_bit;
      next_expanded = expanded_select_bit;
      next_boot = boot_rom_enable;
      next_echo = internal_read_echo;
      next_echo_locked = echo_locked;
      next_prio_sel = prio_sel;
      if (sys_rst) begin
         // Load continues every reset cycle; the last one before release wins.
         next_special = ~pin_stable[1];
         next_expanded = pin_stable[0];
         next_boot = ~pin_stable[1] & ~pin_stable[0];
         next_echo = ~pin_stable[1];
         next_echo_locked = 1'b0;
         next_prio_sel = PRIO_RESET;
      end else if (wr_mode) begin
         // Pins are no longer looked at here; only software changes the mode.
         next_prio_sel = reg_wdata[PRIO_MSB -: PRIO_W];
         next_special = special_variant_bit & reg_wdata[SPECIAL_POS];
         if (special_variant_bit) begin
            next_expanded = reg_wdata[EXPANDED_POS];
            next_boot = reg_wdata[BOOT_ROM_POS];
            if (!echo_locked) begin
               next_echo = reg_wdata[ECHO_POS];
               next_echo_locked = ~reg_wdata[ECHO_POS];
            end
         end
      end
      if (!next_special) begin
         next_echo = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      special_variant_bit <= next_special;
      expanded_select_bit <= next_expanded;
      boot_rom_enable <= next_boot;
      internal_read_echo <= next_echo;
      echo_locked <= next_echo_locked;
      prio_sel <= next_prio_sel;
   end

   // ****************************************************************
   // Setup working register
   // ****************************************************************
   // The EEPROM byte is a dedicated port, apart from the main array data.
   logic [SETUP_BITS-1:0] setup_work;
   logic [SETUP_BITS-1:0] next_setup_work;

   always_comb begin
      next_setup_work = setup_work;
      if (sys_rst) begin
         next_setup_work = setup_eeprom_byte[SETUP_BITS-1:0];
      end else if (DIRECT_SETUP_WRITE && special_variant_bit && wr_setup) begin
         next_setup_work = reg_wdata[SETUP_BITS-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      setup_work <= next_setup_work;
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************
   logic [DATA_W-1:0] mode_word;
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      mode_word = '0;
      mode_word[BOOT_ROM_POS] = boot_rom_enable;
      mode_word[SPECIAL_POS] = special_variant_bit;
      mode_word[EXPANDED_POS] = expanded_select_bit;
      mode_word[ECHO_POS] = internal_read_echo;
      mode_word[PRIO_MSB -: PRIO_W] = prio_sel;
      next_rdata = '0;
      if (rd_mode) begin
         next_rdata = mode_word;
      end else if (rd_setup) begin
         next_rdata = DATA_W'(setup_work);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Pin A marker, boot ROM decode and read echo
   // ****************************************************************
   logic next_marker_oe;
   logic next_boot_hit;
   logic next_ext_oe;
   logic [DATA_W-1:0] next_ext_data;

   always_comb begin
      next_marker_oe = ~sys_rst & instr_start;
      next_boot_hit = ~sys_rst & boot_rom_enable & (cpu_addr >= BOOT_ROM_LO)
         & (cpu_addr <= BOOT_ROM_HI);
      next_ext_oe = ~sys_rst & internal_read_echo & int_read;
      next_ext_data = next_ext_oe ? int_read_data : '0;
   end

   always_ff @(posedge mclk) begin
      mode_pin_a_out <= 1'b0;
      mode_pin_a_oe <= next_marker_oe;
      boot_rom_hit <= next_boot_hit;
      ext_data_oe <= next_ext_oe;
      ext_data_out <= next_ext_data;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_reset_load_special: assert property (
      @(posedge mclk) $fell(sys_rst) |-> special_variant_bit == !$past(pin_stable[1]))
      else $error("special variant bit not loaded from pin B at reset release");

   chk_reset_load_boot: assert property (
      @(posedge mclk) $fell(sys_rst) |->
         boot_rom_enable == (!$past(pin_stable[1]) && !$past(pin_stable[0])))
      else $error("boot ROM enable wrong at reset release");

   chk_special_no_set: assert property (
      @(posedge mclk) disable iff (sys_rst) !special_variant_bit |=> !special_variant_bit)
      else $error("special variant bit was set again");

   chk_mode_pins_ignored: assert property (
      @(posedge mclk) disable iff (sys_rst) !wr_mode |=>
         $stable(expanded_select_bit) && $stable(special_variant_bit))
      else $error("mode bits changed without a register write");

   chk_expanded_guard: assert property (
      @(posedge mclk) disable iff (sys_rst) (wr_mode && !special_variant_bit) |=>
         $stable(expanded_select_bit) && $stable(boot_rom_enable))
      else $error("guarded mode bit written in normal variation");

   chk_echo_forced: assert property (
      @(posedge mclk) disable iff (sys_rst) !special_variant_bit |-> !internal_read_echo)
      else $error("echo bit set while special variant bit is zero");

   chk_echo_lock: assert property (
      @(posedge mclk) disable iff (sys_rst)
         (wr_mode && special_variant_bit && !reg_wdata[ECHO_POS]) |=>
         !internal_read_echo [*3])
      else $error("echo bit rose again after being written zero");

   chk_echo_drive: assert property (
      @(posedge mclk) disable iff (sys_rst) (int_read && internal_read_echo) |=>
         ext_data_oe && ext_data_out == $past(int_read_data))
      else $error("internal read not echoed on the data bus");

   chk_marker_pulse: assert property (
      @(posedge mclk) disable iff (sys_rst) instr_start |=> mode_pin_a_oe && !mode_pin_a_out)
      else $error("instruction start marker not driven low");

   chk_setup_frozen: assert property (
      @(posedge mclk) disable iff (sys_rst)
         !(wr_setup && DIRECT_SETUP_WRITE && special_variant_bit) |=> $stable(setup_work))
      else $error("working setup register changed outside reset");

   chk_read_mode: assert property (
      @(posedge mclk) disable iff (sys_rst) rd_mode |=> reg_rdata == $past(mode_word))
      else $error("mode register read returned wrong data");

   chk_boot_unmapped: assert property (
      @(posedge mclk) disable iff (sys_rst) !boot_rom_enable |=> !boot_rom_hit)
      else $error("boot ROM decoded while disabled");

   chk_reset_load_expanded: assert property (
      @(posedge mclk) $fell(sys_rst)
         |-> expanded_select_bit == $past(pin_stable[0]))
      else $error("expanded select bit not loaded from pin A at reset release");

   chk_reset_load_echo: assert property (
      @(posedge mclk) $fell(sys_rst)
         |-> internal_read_echo == !$past(pin_stable[1]))
      else $error("echo bit wrong at reset release");

   chk_reset_clear_lock: assert property (
      @(posedge mclk) $fell(sys_rst)
         |-> !echo_locked)
      else $error("echo lock survived a reset");

   chk_test_boot_off: assert property (
      @(posedge mclk) $fell(sys_rst) && !$past(pin_stable[1]) && $past(pin_stable[0])
         |-> !boot_rom_enable && special_variant_bit && expanded_select_bit)
      else $error("special test mode left reset with boot ROM enabled");

   chk_normal_boot_off: assert property (
      @(posedge mclk) $fell(sys_rst) && $past(pin_stable[1])
         |-> !boot_rom_enable && !special_variant_bit)
      else $error("normal mode left reset with boot ROM enabled");

   chk_boot_write: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_mode && special_variant_bit
         |=> boot_rom_enable == $past(reg_wdata[BOOT_ROM_POS]))
      else $error("boot ROM enable not written in special variant");

   chk_expanded_write: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_mode && special_variant_bit
         |=> expanded_select_bit == $past(reg_wdata[EXPANDED_POS]))
      else $error("expanded select bit not written in special variant");

   chk_special_clear: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_mode && !reg_wdata[SPECIAL_POS]
         |=> !special_variant_bit)
      else $error("special variant bit not cleared by a write of zero");

   chk_prio_write: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_mode
         |=> prio_sel == $past(reg_wdata[PRIO_MSB -: PRIO_W]))
      else $error("priority field not written");

   chk_echo_write: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_mode && special_variant_bit && !echo_locked
         && reg_wdata[SPECIAL_POS] |=> internal_read_echo == $past(reg_wdata[ECHO_POS]))
      else $error("echo bit not written while unlocked");

   chk_lock_on_clear: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_mode && special_variant_bit && !echo_locked
         && !reg_wdata[ECHO_POS] |=> echo_locked)
      else $error("echo lock not set by a write of zero");

   chk_read_setup: assert property (
      @(posedge mclk) disable iff (sys_rst) rd_setup
         |=> reg_rdata == DATA_W'($past(setup_work)))
      else $error("setup register read did not return the working register");

   chk_read_idle: assert property (
      @(posedge mclk) disable iff (sys_rst) !rd_mode && !rd_setup
         |=> reg_rdata == '0)
      else $error("read data not zero outside a read");

   chk_setup_reload: assert property (
      @(posedge mclk) sys_rst
         |=> setup_work == $past(setup_eeprom_byte[SETUP_BITS-1:0]))
      else $error("working setup register not loaded during reset");

   chk_setup_direct: assert property (
      @(posedge mclk) disable iff (sys_rst) wr_setup && DIRECT_SETUP_WRITE
         && special_variant_bit |=> setup_work == $past(reg_wdata[SETUP_BITS-1:0]))
      else $error("working setup register not written directly");

   chk_marker_reset: assert property (
      @(posedge mclk) sys_rst
         |=> !mode_pin_a_oe)
      else $error("instruction start marker driven during reset");

   chk_marker_idle: assert property (
      @(posedge mclk) disable iff (sys_rst) !instr_start
         |=> !mode_pin_a_oe)
      else $error("instruction start marker driven without an instruction start");

   chk_pin_a_low: assert property (
      @(posedge mclk) disable iff (sys_rst)
         !mode_pin_a_out)
      else $error("pin A output value is not low");

   chk_boot_hit_range: assert property (
      @(posedge mclk) disable iff (sys_rst) !sys_rst && boot_rom_enable
         && cpu_addr >= BOOT_ROM_LO && cpu_addr <= BOOT_ROM_HI |=> boot_rom_hit)
      else $error("boot ROM not decoded inside its window");

   chk_boot_hit_outside: assert property (
      @(posedge mclk) disable iff (sys_rst) cpu_addr < BOOT_ROM_LO || cpu_addr > BOOT_ROM_HI
         |=> !boot_rom_hit)
      else $error("boot ROM decoded outside its window");

   chk_boot_reset: assert property (
      @(posedge mclk) sys_rst
         |=> !boot_rom_hit)
      else $error("boot ROM decoded during reset");

   chk_echo_idle: assert property (
      @(posedge mclk) disable iff (sys_rst) !(int_read && internal_read_echo)
         |=> !ext_data_oe && ext_data_out == '0)
      else $error("data bus driven without an echoed internal read");

endmodule

/* board_straps.sv */
// Board model: mode pin straps with pull resistors and the open-drain pin A wire.
// Assumes the bench sets the strap levels and the device only ever pulls pin A low.
`timescale 1ns/1ps

module board_straps (
   input wire logic strap_a,
   input wire logic strap_b,
   input wire logic pin_a_out,
   input wire logic pin_a_oe,
   output logic pin_a_wire,
   output logic pin_b_wire
);
   // Pin A follows its strap resistor unless the device pulls it down.
   assign pin_a_wire = pin_a_oe ? pin_a_out : strap_a;
   assign pin_b_wire = strap_b;
endmodule

/* tb_mode_select_config_latch.sv */
// Self-checking bench for the mode select and setup latch block.
// Assumes board_straps models the pins; bus and core strobes are driven from here.
`timescale 1ns/1ps

module tb_mode_select_config_latch;
   import mode_cfg_pkg::*;
   localparam int SB = 4;
   localparam logic [7:0] SMASK = (8'h1 << SB) - 8'h1;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic strap_a = 1'b1;
   logic strap_b = 1'b1;
   logic pin_a_wire, pin_b_wire, pin_a_out, pin_a_oe, hit, xoe, spc, exs, boot, echo;
   logic instr_start = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic int_read = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [ADDR_W-1:0] cpu_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic [DATA_W-1:0] setup_eeprom_byte = '0;
   logic [DATA_W-1:0] int_read_data = '0;
   logic [DATA_W-1:0] reg_rdata, xout, eep, d, w, sw;
   logic [8:0] st;
   int seed, op, error_cnt, cmp_count;

   always #25 mclk = ~mclk;

   board_straps board (.strap_a(strap_a), .strap_b(strap_b), .pin_a_out(pin_a_out),
      .pin_a_oe(pin_a_oe), .pin_a_wire(pin_a_wire), .pin_b_wire(pin_b_wire));

   mode_select_config_latch #(.SETUP_BITS(SB), .DIRECT_SETUP_WRITE(1'b1)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .mode_pin_a_in(pin_a_wire), .mode_pin_a_out(pin_a_out),
      .mode_pin_a_oe(pin_a_oe), .mode_pin_b_in(pin_b_wire), .instr_start(instr_start),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .setup_eeprom_byte(setup_eeprom_byte), .cpu_addr(cpu_addr),
      .boot_rom_hit(hit), .int_read(int_read), .int_read_data(int_read_data),
      .ext_data_out(xout), .ext_data_oe(xoe), .special_variant_bit(spc),
      .expanded_select_bit(exs), .boot_rom_enable(boot), .internal_read_echo(echo));

   // ****************************************************************
   // Expected mode register state: bit 8 is the echo lock.
   // ****************************************************************
   function automatic logic [8:0] mode_after(input logic [8:0] s, input logic [7:0] v);
      logic [8:0] n;
      n = s;
      n[3:0] = v[3:0];
      if (s[6]) begin
         n[7:5] = v[7:5];
         if (!s[8]) begin
            n[4] = v[4];
            n[8] = ~v[4];
         end
      end
      if (!n[6]) begin
         n[4] = 1'b0;
      end
      return n;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   task automatic echo_chk(input logic [7:0] v, input logic e);
      @(posedge mclk);
      int_read <= 1'b1;
      int_read_data <= v;
      @(posedge mclk);
      int_read <= 1'b0;
      #1;
      chk({xoe, xout}, e ? {1'b1, v} : 9'h000);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #(50 * 20000);
      error_cnt++;
      finish_test();
   end

   // ****************************************************************
   // Each mode: strap, reset, then random traffic.
   // ****************************************************************
   initial begin
      seed = 32'hcc01;
      for (int m = 0; m < 4; m++) begin
         @(posedge mclk);
         strap_b <= m[1];
         strap_a <= m[0];
         eep = 8'($random(seed));
         sw = eep & SMASK;
         setup_eeprom_byte <= eep;
         sys_rst <= 1'b1;
         repeat (12) @(posedge mclk);
         sys_rst <= 1'b0;
         st = {1'b0, ~m[1] & ~m[0], ~m[1], m[0], ~m[1], 4'h0};
         @(posedge mclk);
         strap_a <= ~m[0];
         strap_b <= ~m[1];
         setup_eeprom_byte <= ~eep;
         #1;
         chk({boot, spc, exs, echo}, st[7:4]);
         echo_chk(eep, st[4]);
         wr(PRIORITY_MODE_ADDR, 8'hc0);
         st = mode_after(st, 8'hc0);
         wr(PRIORITY_MODE_ADDR, 8'hd5);
         st = mode_after(st, 8'hd5);
         rd(PRIORITY_MODE_ADDR, d);
         chk(d, st[7:0]);
         repeat (40) begin
            op = $unsigned($random(seed)) % 6;
            w = 8'($random(seed));
            case (op)
               0: begin
                  wr(PRIORITY_MODE_ADDR, w);
                  st = mode_after(st, w);
               end
               1: begin
                  rd(PRIORITY_MODE_ADDR, d);
                  chk(d, st[7:0]);
                  chk({boot, spc, exs, echo}, st[7:4]);
               end
               2: begin
                  wr(SETUP_WORK_ADDR, w);
                  if (st[6]) begin
                     sw = w & SMASK;
                  end
                  rd(SETUP_WORK_ADDR, d);
                  chk(d, sw);
                  rd(16'h103d, d);
                  chk(d, 8'h00);
               end
               3: begin
                  @(posedge mclk);
                  instr_start <= 1'b1;
                  @(posedge mclk);
                  instr_start <= 1'b0;
                  #1;
                  chk({pin_a_oe, pin_a_wire}, 2'b10);
               end
               4: begin
                  echo_chk(w, st[4]);
               end
               default: begin
                  @(posedge mclk);
                  cpu_addr <= BOOT_ROM_LO - 16'h1 + 16'($unsigned($random(seed)) % 195);
                  @(posedge mclk);
                  #1;
                  chk(hit, st[7] && cpu_addr >= BOOT_ROM_LO && cpu_addr <= BOOT_ROM_HI);
               end
            endcase
         end
      end
      finish_test();
   end
endmodule
